// file: hdl/lfwdt_pkg.sv
// Package: constants and types of the low-frequency watchdog
package lfwdt_pkg;
	localparam int          WB_AW          = 12;
	localparam int          WB_DW          = 32;
	localparam int          IDX_W          = 10;
	localparam int          CNT_W          = 24;
	localparam int          SV_W           = 16;
	localparam int          CNT_OFS        = 8;
	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_START      = 10'h0af;
	localparam logic [9:0]  IDX_CTRL       = 10'h0b0;
	// Control / status fields at IDX_CTRL
	localparam int          CTRL_RET_CLR   = 0;
	localparam int          STAT_ACTIVE    = 1;
	localparam int          STAT_WR_HIGH   = 2;
	localparam int          STAT_RD_HIGH   = 3;
	localparam logic [15:0] START_RST      = 16'h0000;
	localparam logic        RET_CLR_RST    = 1'b0;
	// Low-frequency tick rate and the system clock it is sampled on
	localparam int          LF_FREQ_HZ     = 32768;
	localparam int          SYS_FREQ_HZ    = 40000000;
	localparam int          SYS_PER_LF     = SYS_FREQ_HZ / LF_FREQ_HZ;
	localparam logic [23:0] CNT_ONE        = 24'h000001;

	typedef struct packed {
		logic                cyc;
		logic                stb;
		logic                we;
		logic [WB_AW-1:0]    adr;
		logic [3:0]          sel;
		logic [WB_DW-1:0]    dat;
	} lfwdt_wb_req_type;

	typedef enum logic [2:0] {
		LFWDT_OFF  = 3'b001,
		LFWDT_RUN  = 3'b010,
		LFWDT_FIRE = 3'b100
	} lfwdt_state_type;
endpackage

// file: hdl/lfwdt_top.sv
// Low-frequency watchdog timer with classic Wishbone register access
// Functional notes
// [R1] Countdown advances only on ticks of the 32.768 kHz low-frequency clock.
// [R2] Start value forms counter bits 23:8; bits 7:0 load as zero.
// [R3] Start value is moved as two byte transfers, low byte first.
// [R4] After a write the next read is low; after a read the next write is low.
// [R5] Software keeps both byte writes, or both reads, free of the other kind.
// [R6] Reads return the stored start value, never the live counter.
// [R7] After any reset the watchdog is disabled and does not count.
// [R8] Writing both bytes of the start value activates the watchdog.
// [R9] Active counter counts down toward zero from start value times 256.
// [R10] Reaching zero resets the whole microcontroller and its peripherals.
// [R11] Watchdog reset acts exactly like power-on or pin reset.
// [R12] Every complete start value write reloads the counter and restarts.
// [R13] Software rewrites the start value before the counter reaches zero.
// [R14] Timeout is start value times 256 over 32768 s; least 7.8125 ms.
// [R15] Start value zero gives the longest timeout of 512 s, not disable.
// [R16] Once started only system reset or configured retention entry stops it.
// [R17] Software keeps a 32.768 kHz source enabled while the watchdog is used.
// [R18] In memory retention with timers on, counting continues on the slow clock.
// [R19] A lone low byte write neither starts nor restarts the counter.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
module lfwdt_top
	import lfwdt_pkg::*;
(
	// System
	input  wire logic             clk_sys,
	input  wire logic             srst,
	// Wishbone slave
	input  wire lfwdt_wb_req_type wb_req,
	output logic                  wb_ack,
	output logic [WB_DW-1:0]      wb_dat_o,
	// Low-frequency clock pin, sampled as data
	input  wire logic             lf_clk_in,
	// Power manager: one-cycle pulse on entry to a retention power-down mode
	input  wire logic             retention_entry,
	// System reset request, held until the reset network answers on srst
	output logic                  wdt_reset_req,
	output logic                  wdt_active
);

	logic            lf_s1_r, lf_s2_r, lf_s3_r;
	logic            lf_tick;
	logic            ack_r, ack_nxt;
	logic [31:0]     dat_r, dat_nxt;
	logic [15:0]     start_r, start_nxt;
	logic [7:0]      low_hold_r, low_hold_nxt;
	logic            wr_high_r, wr_high_nxt;
	logic            rd_high_r, rd_high_nxt;
	logic            ret_clr_r, ret_clr_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	lfwdt_state_type state_r, state_nxt;
	logic            req, hit_start, hit_ctrl, lane0;
	logic            wr_start, rd_start, commit;
	logic [IDX_W-1:0] idx;

	// Two-stage synchroniser; the edge detector looks only at stages two and three
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lf_s1_r <= 1'b0;
			lf_s2_r <= 1'b0;
			lf_s3_r <= 1'b0;
		end else begin
			lf_s1_r <= lf_clk_in;
			lf_s2_r <= lf_s1_r;
			lf_s3_r <= lf_s2_r;
		end
	end
	assign lf_tick = lf_s2_r & ~lf_s3_r; // [R1]

	assign idx       = wb_req.adr[WB_AW-1:2];
	assign req       = wb_req.cyc & wb_req.stb & ~ack_r;
	assign lane0     = wb_req.sel[0];
	assign hit_start = (idx == IDX_START);
	assign hit_ctrl  = (idx == IDX_CTRL);
	// Only lane 0 carries the byte; other lanes are ignored, not an error
	assign wr_start  = req & hit_start & wb_req.we & lane0;
	assign rd_start  = req & hit_start & ~wb_req.we;
	assign commit    = wr_start & wr_high_r; // [R8] [R19]

	always_comb begin
		ack_nxt      = req;
		dat_nxt      = dat_r;
		start_nxt    = start_r;
		low_hold_nxt = low_hold_r;
		wr_high_nxt  = wr_high_r;
		rd_high_nxt  = rd_high_r;
		ret_clr_nxt  = ret_clr_r;
		cnt_nxt      = cnt_r;
		state_nxt    = state_r;
		if (req & ~wb_req.we) begin
			dat_nxt = 32'h0000_0000;
		end
		// Byte sequencing of the start value
		if (wr_start) begin
			rd_high_nxt = 1'b0; // [R4]
			wr_high_nxt = ~wr_high_r; // [R3]
			if (!wr_high_r) begin
				low_hold_nxt = wb_req.dat[7:0];
			end else begin
				start_nxt = {wb_req.dat[7:0], low_hold_r};
			end
		end
		if (rd_start) begin
			wr_high_nxt = 1'b0; // [R4]
			rd_high_nxt = ~rd_high_r; // [R3]
			dat_nxt     = {24'h00_0000, rd_high_r ? start_r[15:8] : start_r[7:0]}; // [R6]
		end
		if (req & hit_ctrl & wb_req.we & lane0) begin
			ret_clr_nxt = wb_req.dat[CTRL_RET_CLR];
		end
		if (req & hit_ctrl & ~wb_req.we) begin
			dat_nxt = '0;
			dat_nxt[CTRL_RET_CLR] = ret_clr_r;
			dat_nxt[STAT_ACTIVE]  = (state_r != LFWDT_OFF);
			dat_nxt[STAT_WR_HIGH] = wr_high_r;
			dat_nxt[STAT_RD_HIGH] = rd_high_r;
		end
		// Countdown; a start value of zero wraps to the full 2^24 ticks
		unique case (state_r)
			LFWDT_OFF: begin
				if (commit) begin
					cnt_nxt   = {wb_req.dat[7:0], low_hold_r, 8'h00}; // [R2] [R15]
					state_nxt = LFWDT_RUN; // [R8]
				end
			end
			LFWDT_RUN: begin
				if (commit) begin
					cnt_nxt = {wb_req.dat[7:0], low_hold_r, 8'h00}; // [R12]
				end else if (lf_tick) begin
					cnt_nxt = cnt_r - CNT_ONE; // [R9] [R14]
					if (cnt_r == CNT_ONE) begin
						state_nxt = LFWDT_FIRE; // [R10]
					end
				end
				// Retention entry stops it only when software asked for that
				if (retention_entry && ret_clr_r) begin
					state_nxt = LFWDT_OFF; // [R16] [R18]
				end
			end
			LFWDT_FIRE: begin
				state_nxt = LFWDT_FIRE; // [R11]
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ack_r      <= 1'b0;
			dat_r      <= 32'h0000_0000;
			start_r    <= START_RST;
			low_hold_r <= 8'h00;
			wr_high_r  <= 1'b0;
			rd_high_r  <= 1'b0;
			ret_clr_r  <= RET_CLR_RST;
			cnt_r      <= 24'h00_0000;
			state_r    <= LFWDT_OFF; // [R7]
		end else begin
			ack_r      <= ack_nxt;
			dat_r      <= dat_nxt;
			start_r    <= start_nxt;
			low_hold_r <= low_hold_nxt;
			wr_high_r  <= wr_high_nxt;
			rd_high_r  <= rd_high_nxt;
			ret_clr_r  <= ret_clr_nxt;
			cnt_r      <= cnt_nxt;
			state_r    <= state_nxt;
		end
	end

	assign wb_ack        = ack_r;
	assign wb_dat_o      = dat_r;
	// Fed into the same reset network as power-on and pin reset
	assign wdt_reset_req = (state_r == LFWDT_FIRE); // [R10] [R11]
	assign wdt_active    = (state_r != LFWDT_OFF);

	// Checks

	// Reset itself is checked without the usual disable, since it is the event under test
	reset_clear_a: assert property (@(posedge clk_sys) // [R7] [R11]
		srst
		|=> !wb_ack && wb_dat_o == 32'h0000_0000 && state_r == LFWDT_OFF)
		else $error("reset did not clear the watchdog");

	off_quiet_a: assert property (@(posedge clk_sys) disable iff (srst) // [R7]
		(state_r == LFWDT_OFF)
		|-> !wdt_reset_req && !wdt_active)
		else $error("disabled watchdog asserts reset or active");

	off_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // [R7]
		state_r == LFWDT_OFF && !commit
		|=> state_r == LFWDT_OFF && cnt_r == $past(cnt_r))
		else $error("disabled watchdog started without a full start write");

	// Byte sequencing of the start value
	wrptr_step_a: assert property (@(posedge clk_sys) disable iff (srst) // [R3]
		wr_start
		|=> wr_high_r == !$past(wr_high_r))
		else $error("write pointer did not alternate");

	ptr_after_a: assert property (@(posedge clk_sys) disable iff (srst) // [R4]
		wr_start
		|=> !rd_high_r)
		else $error("write did not return the read pointer to the low byte");

	rdptr_after_a: assert property (@(posedge clk_sys) disable iff (srst) // [R4]
		rd_start
		|=> !wr_high_r && rd_high_r == !$past(rd_high_r))
		else $error("read did not return the write pointer to the low byte");

	stray_wr_a: assert property (@(posedge clk_sys) disable iff (srst) // [R3]
		req && wb_req.we && !hit_start
		|=> wr_high_r == $past(wr_high_r) && start_r == $past(start_r))
		else $error("write elsewhere disturbed the start value sequence");

	low_only_a: assert property (@(posedge clk_sys) disable iff (srst) // [R19]
		wr_start && !wr_high_r && !retention_entry && !lf_tick
		|=> wr_high_r && cnt_r == $past(cnt_r) && state_r == $past(state_r))
		else $error("lone low byte write changed the counter");

	// Readback path
	readback_a: assert property (@(posedge clk_sys) disable iff (srst) // [R6]
		rd_start
		|=> wb_dat_o[7:0] == ($past(rd_high_r) ? start_r[15:8] : start_r[7:0])
		&& wb_dat_o[31:8] == 24'h00_0000)
		else $error("start value readback wrong");

	start_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // [R6]
		!commit
		|=> start_r == $past(start_r))
		else $error("stored start value changed without a full write");

	stray_rd_a: assert property (@(posedge clk_sys) disable iff (srst)
		req && !wb_req.we && !hit_start && !hit_ctrl
		|=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read returned data");

	// Counter; while running, retention clear wins over a reload in the same cycle; while off, a full write starts it
	reload_a: assert property (@(posedge clk_sys) disable iff (srst) // [R2] [R8] [R12]
		commit && state_r != LFWDT_FIRE && !(retention_entry && ret_clr_r)
		|=> cnt_r[7:0] == 8'h00 && cnt_r[23:8] == start_r && state_r == LFWDT_RUN)
		else $error("full start write did not reload and run the counter");

	count_a: assert property (@(posedge clk_sys) disable iff (srst) // [R1] [R9]
		state_r == LFWDT_RUN && lf_tick && !commit && cnt_r != CNT_ONE
		|=> cnt_r == $past(cnt_r) - CNT_ONE)
		else $error("counter did not step down on a low-frequency tick");

	hold_a: assert property (@(posedge clk_sys) disable iff (srst) // [R1]
		state_r == LFWDT_RUN && !lf_tick && !commit
		|=> cnt_r == $past(cnt_r))
		else $error("counter moved without a low-frequency tick");

	zero_wrap_a: assert property (@(posedge clk_sys) disable iff (srst) // [R15]
		state_r == LFWDT_RUN && lf_tick && !commit && cnt_r == 24'h00_0000
		&& !(retention_entry && ret_clr_r)
		|=> cnt_r == 24'hff_ffff && state_r == LFWDT_RUN)
		else $error("zero start value did not give the longest interval");

	// The reset request loops back onto srst, so this one must not be disabled by it
	fire_a: assert property (@(posedge clk_sys) // [R10] [R11]
		!srst && state_r == LFWDT_RUN && lf_tick && !commit && cnt_r == CNT_ONE
		&& !(retention_entry && ret_clr_r)
		|=> wdt_reset_req)
		else $error("reset request missing at zero");

	// Stopping rules
	no_stop_a: assert property (@(posedge clk_sys) disable iff (srst) // [R16] [R18]
		state_r != LFWDT_OFF && !(retention_entry && ret_clr_r)
		|=> state_r != LFWDT_OFF)
		else $error("watchdog stopped without reset or retention clear");

	ret_keep_a: assert property (@(posedge clk_sys) disable iff (srst) // [R18]
		state_r == LFWDT_RUN && retention_entry && !ret_clr_r
		&& !(lf_tick && cnt_r == CNT_ONE)
		|=> state_r == LFWDT_RUN)
		else $error("timers-on retention stopped the watchdog");

	ret_stop_a: assert property (@(posedge clk_sys) disable iff (srst) // [R16]
		state_r == LFWDT_RUN && retention_entry && ret_clr_r
		|=> state_r == LFWDT_OFF && !wdt_reset_req)
		else $error("configured retention entry did not stop the watchdog");

	// Bus handshake
	ack_once_a: assert property (@(posedge clk_sys) disable iff (srst)
		req
		|=> wb_ack ##1 !wb_ack)
		else $error("wishbone ack not a single cycle");

	ack_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
		wb_ack
		|-> $past(req))
		else $error("wishbone ack without a request");

	dat_stand_a: assert property (@(posedge clk_sys) disable iff (srst)
		!(req && !wb_req.we)
		|=> wb_dat_o == $past(wb_dat_o))
		else $error("read data changed without a read");

	start_cv: cover property (@(posedge clk_sys) disable iff (srst)
		state_r == LFWDT_OFF ##1 state_r == LFWDT_RUN);
	reload_cv: cover property (@(posedge clk_sys) disable iff (srst)
		state_r == LFWDT_RUN && commit);
	fire_cv: cover property (@(posedge clk_sys) wdt_reset_req);
	ret_cv: cover property (@(posedge clk_sys) disable iff (srst)
		state_r == LFWDT_RUN && retention_entry && ret_clr_r);
	zero_cv: cover property (@(posedge clk_sys) disable iff (srst)
		state_r == LFWDT_RUN && lf_tick && cnt_r == 24'h00_0000);

endmodule

// file: bench/lfwdt_tb_top.sv
// Self-checking bench of the low-frequency watchdog
`timescale 1ns/1ps
module lfwdt_tb_top;
	import lfwdt_pkg::*;
	logic             clk_sys         = 1'b0;
	logic             bench_rst       = 1'b1;
	logic             srst;
	lfwdt_wb_req_type wb_req          = '0;
	logic             wb_ack;
	logic [WB_DW-1:0] wb_dat_o;
	logic             lf_clk_in       = 1'b0;
	logic             retention_entry = 1'b0;
	logic             wdt_reset_req;
	logic             wdt_active;
	logic [31:0]      q;
	logic [31:0]      rnd             = 32'h3f3b;
	int               fires           = 0;
	int               n_fail          = 0;
	int               samples_checked = 0;
	// The request only lives one cycle, so it is counted here
	assign srst = bench_rst | wdt_reset_req;
	always @(posedge clk_sys) if (wdt_reset_req === 1'b1) fires <= fires + 1;
	lfwdt_top dut (.clk_sys(clk_sys), .srst(srst), .wb_req(wb_req), .wb_ack(wb_ack),
		.wb_dat_o(wb_dat_o), .lf_clk_in(lf_clk_in), .retention_entry(retention_entry),
		.wdt_reset_req(wdt_reset_req), .wdt_active(wdt_active));
	initial forever #12.5 clk_sys = ~clk_sys;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_sys);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
		for (i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			if (wb_ack === 1'b1) break;
		end
		q = wb_dat_o;
		wb_req <= '0;
		if (i == 16) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	task automatic wsv(input logic [15:0] v);
		wb(1'b1, 12'h2bc, v[7:0]);
		wb(1'b1, 12'h2bc, v[15:8]);
	endtask
	task automatic rsv(input logic [15:0] v);
		rd(12'h2bc, {24'h0, v[7:0]});
		rd(12'h2bc, {24'h0, v[15:8]});
	endtask
	// Pin runs far above 32.768 kHz to keep the run short; it is sampled as data
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_sys) lf_clk_in <= 1'b1;
			repeat (3) @(posedge clk_sys);
			lf_clk_in <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic retain;
		@(posedge clk_sys) retention_entry <= 1'b1;
		@(posedge clk_sys) retention_entry <= 1'b0;
		@(posedge clk_sys);
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_fail++;
		give_verdict();
	end
	initial begin
		logic [15:0] v;
		repeat (20) @(posedge clk_sys);
		bench_rst <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, wdt_active}, 32'h0);
		rsv(START_RST);
		wb(1'b1, 12'h2bc, 8'h11);
		wb(1'b0, 12'h2bc, 8'h00);
		wb(1'b1, 12'h2bc, 8'h22);
		chk({31'h0, wdt_active}, 32'h0);
		wb(1'b1, 12'h2bc, 8'h33);
		chk({31'h0, wdt_active}, 32'h1);
		rsv(16'h3322);
		rd(12'h004, 32'h0);
		wb(1'b0, 12'h2c0, 8'h00);
		chk(q & 32'h3, 32'h2);
		repeat (4) begin
			rnd = lfsr(rnd);
			v = rnd[15:0];
			wsv(v);
			rsv(v);
		end
		wsv(16'h0001);
		ticks(200);
		retain();
		wsv(16'h0001);
		ticks(255);
		chk(fires, 32'h0);
		chk({31'h0, wdt_active}, 32'h1);
		ticks(1);
		chk(fires, 32'h1);
		chk({31'h0, wdt_active}, 32'h0);
		rsv(START_RST);
		wb(1'b1, 12'h2c0, 8'h01);
		wsv(16'h0000);
		ticks(300);
		chk(fires, 32'h1);
		chk({31'h0, wdt_active}, 32'h1);
		retain();
		chk({31'h0, wdt_active}, 32'h0);
		give_verdict();
	end
endmodule
